// file: assd_core.sv
/*
 * execution datapath for the register and immediate accumulator shifts,
 * one and four step shifts, squaring and the three subtract forms.
 * assumes the sequencer presents one decoded operation per cycle with its
 * condition already evaluated, and holds off while OP_READY is low.
 */
// Function
// - shift by register amount, -36..36
// - register shift only when condition true
// - arithmetic: overflow cleared for amount <= 0
// - left shift below 36: overflow if not fitting
// - amount 36: overflow iff source non-zero
// - register shift: zero amount clears carry
// - logical keeps limit, rounding; arithmetic updates limit
// - distinct source untouched; zero amount is move
// - signed 6-bit immediate shift, source untouched
// - immediate arithmetic overflow by fit check
// - immediate logical keeps overflow; zero clears carry
// - all accumulators are 36 bits
// - one-bit left or right shift, conditional
// - four-bit left or right shift, conditional
// - square into product, one cycle, flags kept
// - accumulate shifted product, then square anew
// - subtract from A; long plain form takes two cycles
// - plain subtract rejects B accumulators
// - high subtract scales by 2^16, low kept
// - low subtract zero-extends operand
// - high, low, square reject accumulators, product
`timescale 1ns/1ns
module assd_core
  import assd_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic OP_VALID,
  input wire assd_op_e OP_CODE,
  input wire logic COND_TRUE,
  input wire logic ARITH_MODE,
  input wire logic [1:0] SRC_SEL,
  input wire logic [1:0] DST_SEL,
  input wire logic signed [WORD_W-1:0] SHIFT_AMOUNT_REGISTER,
  input wire logic signed [IMM_W-1:0] SHIFT_IMM,
  input wire logic [WORD_W-1:0] OPERAND,
  input wire logic [1:0] OPERAND_CLASS,
  input wire logic OPERAND_LONG,
  input wire logic [1:0] PRODUCT_SHIFT,
  output logic OP_READY,
  output logic DONE,
  output logic REJECT,
  output logic [ACC_W-1:0] ACC_A0_OUT,
  output logic [ACC_W-1:0] ACC_A1_OUT,
  output logic [ACC_W-1:0] ACC_B0_OUT,
  output logic [ACC_W-1:0] ACC_B1_OUT,
  output logic [PROD_W-1:0] PRODUCT,
  output logic [7:0] FLAGS
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [3:0][ACC_W-1:0] acc;
    logic [PROD_W-1:0] prod;
    logic [7:0] flg;
    assd_state_e st;
    logic [0:0] pend_dst;
    logic done;
    logic rej;
  } assd_regs_s;

  assd_regs_s s_q;
  assd_regs_s s_d;
  logic accept;
  logic [ACC_W-1:0] src_w;

  // ***************************************************************
  // helpers
  // ***************************************************************
  // shift returning {overflow, carry, result}
  function automatic logic [ACC_W+1:0] do_shift(input logic [ACC_W-1:0] src,
                                                input logic signed [AMT_W-1:0] amt,
                                                input logic arith);
    logic [ACC_W:0] w;
    logic [ACC_W-1:0] res;
    logic [5:0] n;
    logic v;
    logic c;
    w = '0;
    res = src;
    n = '0;
    v = 1'b0;
    c = 1'b0;
    if (amt > 0) begin
      n = 6'(amt);
      w = {1'b0, src} << n;
      res = w[ACC_W-1:0];
      c = w[ACC_W];
      // fit check: shifting back must restore the source
      if (amt == SHIFT_MAX) begin
        v = |src;
      end else begin
        v = (($signed(res) >>> n) != $signed(src));
      end
    end else if (amt < 0) begin
      n = 6'(-amt);
      if (arith) begin
        w = $signed({src, 1'b0}) >>> n; // sign fills from the top
      end else begin
        w = {src, 1'b0} >> n;
      end
      res = w[ACC_W:1];
      c = w[0];
    end
    return {v, c, res};
  endfunction
  // zero, minus, normalized and extension from a result
  function automatic logic [3:0] res_flags(input logic [ACC_W-1:0] r);
    logic e;
    e = !((&r[SIGN_POS:NORM_POS]) || !(|r[SIGN_POS:NORM_POS]));
    return {~|r, r[SIGN_POS], ~e & (r[NORM_POS] ^ r[NORM_POS-1]), e};
  endfunction
  // full flag vector after an arithmetic update; rounding always kept
  function automatic logic [7:0] alu_flags(input logic [ACC_W-1:0] r,
                                           input logic v, input logic c,
                                           input logic [7:0] old);
    logic [3:0] f;
    f = res_flags(r);
    return {f[3], f[2], f[1], v, c, f[0], v, old[FR]};
  endfunction
  // add or subtract with 36-bit overflow and carry, {v, c, result}
  function automatic logic [ACC_W+1:0] addsub(input logic [ACC_W-1:0] a,
                                              input logic [ACC_W-1:0] b,
                                              input logic sub);
    logic [ACC_W:0] w;
    logic [ACC_W-1:0] bb;
    logic v;
    bb = sub ? ~b : b;
    w = {1'b0, a} + {1'b0, bb} + {{ACC_W{1'b0}}, sub};
    v = (a[SIGN_POS] == bb[SIGN_POS]) && (w[SIGN_POS] != a[SIGN_POS]);
    // carry out for add, borrow for subtract
    return {v, sub ? ~w[ACC_W] : w[ACC_W], w[ACC_W-1:0]};
  endfunction
  assign src_w = s_q.acc[SRC_SEL];
  // long subtract holds the sequencer for its second word
  assign OP_READY = (s_q.st == ST_IDLE);
  assign accept = OP_VALID && OP_READY;

  // ***************************************************************
  // next state
  // ***************************************************************
  // one combinational pass computes every operation in the cycle
  always_comb begin
    logic signed [AMT_W-1:0] amt;
    logic [ACC_W+1:0] sh;
    logic [ACC_W+1:0] as;
    logic [ACC_W-1:0] opx;
    logic [ACC_W-1:0] pext;
    logic [3:0] rf;
    logic [1:0] a_idx;
    logic is_shift;
    s_d = s_q;
    amt = '0;
    sh = '0;
    as = '0;
    opx = '0;
    pext = '0;
    rf = '0;
    a_idx = {1'b0, DST_SEL[0]};
    is_shift = 1'b0;
    s_d.done = 1'b0;
    s_d.rej = 1'b0;
    if (s_q.st == ST_SECOND) begin
      opx = {{(ACC_W-WORD_W){OPERAND[WORD_W-1]}}, OPERAND};
      as = addsub(s_q.acc[{1'b0, s_q.pend_dst}], opx, 1'b1);
      s_d.acc[{1'b0, s_q.pend_dst}] = as[ACC_W-1:0];
      s_d.flg = alu_flags(as[ACC_W-1:0], as[ACC_W+1], as[ACC_W], s_q.flg);
      s_d.st = ST_IDLE;
      s_d.done = 1'b1;
    end else if (accept) begin
      s_d.done = 1'b1;
      unique case (OP_CODE)
        OP_SHIFT_REG: begin
          // clamp register amount to the legal span
          if (SHIFT_AMOUNT_REGISTER > WORD_W'(SHIFT_MAX)) begin
            amt = SHIFT_MAX;
          end else if (SHIFT_AMOUNT_REGISTER < WORD_W'(SHIFT_MIN)) begin
            amt = SHIFT_MIN;
          end else begin
            amt = AMT_W'(SHIFT_AMOUNT_REGISTER);
          end
          is_shift = COND_TRUE; // false condition leaves all
        end
        OP_SHIFT_IMM: begin
          amt = AMT_W'(SHIFT_IMM);
          is_shift = 1'b1;
        end
        OP_SHL1, OP_SHR1, OP_LEFT_FOUR_BITS, OP_RIGHT_FOUR_BITS: begin
          amt = (OP_CODE == OP_SHL1 || OP_CODE == OP_SHR1) ? STEP_ONE : STEP_FOUR;
          if (OP_CODE == OP_SHR1 || OP_CODE == OP_RIGHT_FOUR_BITS) begin
            amt = -amt;
          end
          is_shift = COND_TRUE;
        end
        OP_SQR, OP_SQRA: begin
          // accumulators and product refused as operand
          if (OPERAND_CLASS != CLS_OTHER) begin
            s_d.rej = 1'b1;
          end else begin
            if (OP_CODE == OP_SQRA) begin
              pext = {{(ACC_W-PROD_W){s_q.prod[PROD_W-1]}}, s_q.prod};
              unique case (PRODUCT_SHIFT)
                PSH_NONE: pext = pext;
                PSH_LEFT1: pext = pext << 1;
                PSH_RIGHT1: pext = ACC_W'($signed(pext) >>> 1);
                PSH_LEFT2: pext = pext << 2;
              endcase
              as = addsub(s_q.acc[a_idx], pext, 1'b0);
              s_d.acc[a_idx] = as[ACC_W-1:0];
              s_d.flg = alu_flags(as[ACC_W-1:0], as[ACC_W+1], as[ACC_W], s_q.flg);
            end
            s_d.prod = PROD_W'($signed(OPERAND) * $signed(OPERAND));
          end
        end
        OP_SUB, OP_SUBH, OP_SUBL: begin
          // plain form refuses only B accumulators
          if ((OP_CODE == OP_SUB && OPERAND_CLASS == CLS_B_ACC) ||
              (OP_CODE != OP_SUB && OPERAND_CLASS != CLS_OTHER)) begin
            s_d.rej = 1'b1; // high and low forms refuse more
          end else if (OP_CODE == OP_SUB && OPERAND_LONG) begin
            // two-word form waits for its second word
            s_d.st = ST_SECOND;
            s_d.pend_dst = DST_SEL[0];
            s_d.done = 1'b0;
          end else begin
            unique case (OP_CODE)
              // operand weighted by 2^16, low word unchanged
              OP_SUBH: opx = {{(ACC_W-WORD_W-HIGH_POS){OPERAND[WORD_W-1]}}, OPERAND, {HIGH_POS{1'b0}}};
              OP_SUBL: opx = {{(ACC_W-WORD_W){1'b0}}, OPERAND};
              default: opx = {{(ACC_W-WORD_W){OPERAND[WORD_W-1]}}, OPERAND};
            endcase
            // full flag update from the 36-bit difference
            as = addsub(s_q.acc[a_idx], opx, 1'b1);
            s_d.acc[a_idx] = as[ACC_W-1:0];
            s_d.flg = alu_flags(as[ACC_W-1:0], as[ACC_W+1], as[ACC_W], s_q.flg);
          end
        end
        default: s_d.done = 1'b0;
      endcase
      if (is_shift) begin
        // full 36-bit shift into the destination only
        sh = do_shift(src_w, amt, ARITH_MODE);
        // source is only read, so a distinct source stays
        s_d.acc[DST_SEL] = sh[ACC_W-1:0];
        rf = res_flags(sh[ACC_W-1:0]);
        s_d.flg[FZ] = rf[3];
        s_d.flg[FM] = rf[2];
        s_d.flg[FN] = rf[1];
        s_d.flg[FE] = rf[0];
        s_d.flg[FC] = sh[ACC_W];
        if (ARITH_MODE) begin
          s_d.flg[FV] = sh[ACC_W+1];
          // limit follows overflow in arithmetic mode
          s_d.flg[FL] = sh[ACC_W+1];
        end else if (OP_CODE == OP_SHIFT_REG) begin
          s_d.flg[FV] = 1'b0; // logical register shift never overflows
        end
        // logical immediate keeps overflow and limit
      end
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ACC_A0_OUT = s_q.acc[ACC_A0];
  assign ACC_A1_OUT = s_q.acc[ACC_A1];
  assign ACC_B0_OUT = s_q.acc[ACC_B0];
  assign ACC_B1_OUT = s_q.acc[ACC_B1];
  assign PRODUCT = s_q.prod;
  assign FLAGS = s_q.flg;
  assign DONE = s_q.done;
  assign REJECT = s_q.rej;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  sequence s_reg_shift;
    accept && OP_CODE == OP_SHIFT_REG && COND_TRUE;
  endsequence
  sequence s_long_wait;
    !OP_READY ##1 OP_READY && DONE;
  endsequence
  property p_cond_false;
    accept && OP_CODE == OP_SHIFT_REG && !COND_TRUE |=> $stable(s_q.acc) && $stable(FLAGS);
  endproperty
  a_cond_false: assert property (p_cond_false) else $error("false condition changed state");
  property p_zero_carry;
    s_reg_shift and (SHIFT_AMOUNT_REGISTER == 0) |=> !FLAGS[FC];
  endproperty
  a_zero_carry: assert property (p_zero_carry) else $error("carry set on zero shift");
  property p_right_no_ovf;
    s_reg_shift and (ARITH_MODE && SHIFT_AMOUNT_REGISTER <= 0) |=> !FLAGS[FV];
  endproperty
  a_right_no_ovf: assert property (p_right_no_ovf) else $error("overflow on right shift");
  property p_full_shift_ovf;
    s_reg_shift and (ARITH_MODE && SHIFT_AMOUNT_REGISTER == WORD_W'(SHIFT_MAX))
      |=> FLAGS[FV] == ($past(src_w) != '0) && s_q.acc[$past(DST_SEL)] == '0;
  endproperty
  a_full_shift_ovf: assert property (p_full_shift_ovf) else $error("wrong overflow at 36");
  property p_move;
    s_reg_shift and (SHIFT_AMOUNT_REGISTER == 0 && SRC_SEL != DST_SEL)
      |=> s_q.acc[$past(DST_SEL)] == $past(src_w) && s_q.acc[$past(SRC_SEL)] == $past(src_w);
  endproperty
  a_move: assert property (p_move) else $error("conditional move wrong");
  property p_square;
    accept && OP_CODE == OP_SQR && OPERAND_CLASS == CLS_OTHER
      |=> PRODUCT == PROD_W'($signed($past(OPERAND)) * $signed($past(OPERAND))) && $stable(FLAGS);
  endproperty
  a_square: assert property (p_square) else $error("square result wrong");
  property p_long_sub;
    accept && OP_CODE == OP_SUB && OPERAND_LONG && OPERAND_CLASS != CLS_B_ACC |=> s_long_wait;
  endproperty
  a_long_sub: assert property (p_long_sub) else $error("long subtract not two cycles");
  property p_subh_low;
    accept && OP_CODE == OP_SUBH && OPERAND_CLASS == CLS_OTHER
      |=> s_q.acc[{1'b0, $past(DST_SEL[0])}][HIGH_POS-1:0] == $past(s_q.acc[{1'b0, DST_SEL[0]}][HIGH_POS-1:0]);
  endproperty
  a_subh_low: assert property (p_subh_low) else $error("high subtract touched low word");
  property p_reject;
    accept && (OP_CODE == OP_SUBL || OP_CODE == OP_SUBH) && OPERAND_CLASS != CLS_OTHER
      |=> REJECT && $stable(s_q.acc) && $stable(FLAGS);
  endproperty
  a_reject: assert property (p_reject) else $error("illegal operand not refused");
  property p_subl_zext;
    accept && OP_CODE == OP_SUBL && OPERAND_CLASS == CLS_OTHER
      |=> s_q.acc[{1'b0, $past(DST_SEL[0])}] ==
          ACC_W'($past(s_q.acc[{1'b0, DST_SEL[0]}]) - {{(ACC_W-WORD_W){1'b0}}, $past(OPERAND)});
  endproperty
  a_subl_zext: assert property (p_subl_zext) else $error("low subtract extended sign");
  property p_round_kept;
    accept |=> $stable(FLAGS[FR]);
  endproperty
  a_round_kept: assert property (p_round_kept) else $error("rounding flag changed");

endmodule

// file: assd_pkg.sv
/*
 * constants, opcodes and states for the accumulator shift, square and
 * subtract datapath.
 * assumes a single core clock domain shared with the instruction sequencer.
 */
package assd_pkg;

  // ***************************************************************
  // widths and limits
  // ***************************************************************
  localparam int ACC_W = 36;
  localparam int WORD_W = 16;
  localparam int PROD_W = 32;
  localparam int IMM_W = 6;
  localparam int AMT_W = 8;
  localparam logic signed [AMT_W-1:0] SHIFT_MAX = 8'sh24; // 36 positions
  localparam logic signed [AMT_W-1:0] SHIFT_MIN = -8'sh24;
  localparam logic signed [AMT_W-1:0] STEP_ONE = 8'sh01;
  localparam logic signed [AMT_W-1:0] STEP_FOUR = 8'sh04;
  localparam int HIGH_POS = 16; // weight of the high-word operand
  localparam int SIGN_POS = 35;
  localparam int NORM_POS = 31;

  // ***************************************************************
  // accumulator indices and operand classes
  // ***************************************************************
  localparam logic [1:0] ACC_A0 = 2'h0;
  localparam logic [1:0] ACC_A1 = 2'h1;
  localparam logic [1:0] ACC_B0 = 2'h2;
  localparam logic [1:0] ACC_B1 = 2'h3;
  localparam logic [1:0] CLS_OTHER = 2'h0; // memory or ordinary register
  localparam logic [1:0] CLS_A_ACC = 2'h1;
  localparam logic [1:0] CLS_B_ACC = 2'h2;
  localparam logic [1:0] CLS_PROD = 2'h3;

  // product output shifter settings
  localparam logic [1:0] PSH_NONE = 2'h0;
  localparam logic [1:0] PSH_LEFT1 = 2'h1;
  localparam logic [1:0] PSH_RIGHT1 = 2'h2;
  localparam logic [1:0] PSH_LEFT2 = 2'h3;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [3:0] {
    OP_NONE, OP_SHIFT_REG, OP_SHIFT_IMM, OP_SHL1, OP_SHR1,
    OP_LEFT_FOUR_BITS, OP_RIGHT_FOUR_BITS, OP_SQR, OP_SQRA,
    OP_SUB, OP_SUBH, OP_SUBL
  } assd_op_e;

  typedef enum logic [0:0] {ST_IDLE, ST_SECOND} assd_state_e;

  // flag vector order, msb first: z m n v c e l r
  localparam int FZ = 7;
  localparam int FM = 6;
  localparam int FN = 5;
  localparam int FV = 4;
  localparam int FC = 3;
  localparam int FE = 2;
  localparam int FL = 1;
  localparam int FR = 0;

endpackage

// file: assd_core_tb.sv
/*
 * self-checking bench for the accumulator shift, square and subtract
 * datapath: drives decoded operations and compares accumulators, product
 * and flags with values worked out by hand.
 * assumes assd_pkg is compiled first and a single 20 MHz core clock.
 */
`timescale 1ns/1ns
module assd_core_tb;
  import assd_pkg::*;

  // ***************************************************************
  // stimulus and observed signals
  // ***************************************************************
  logic ref_clk = 1'b0;
  logic reset;
  logic op_valid;
  assd_op_e op_code;
  logic cond_true;
  logic arith_mode;
  logic operand_long;
  logic [1:0] src_sel;
  logic [1:0] dst_sel;
  logic [1:0] operand_class;
  logic [1:0] product_shift;
  logic signed [WORD_W-1:0] shift_amt;
  logic signed [IMM_W-1:0] shift_imm;
  logic [WORD_W-1:0] operand;
  logic op_ready, done, reject;
  logic [ACC_W-1:0] acc_a0, acc_a1, acc_b0, acc_b1;
  logic [PROD_W-1:0] product;
  logic [7:0] flags;
  int failures = 0;
  int total_checks = 0;

  assd_core u_assd_core (
    .REF_CLK(ref_clk), .RESET(reset), .OP_VALID(op_valid), .OP_CODE(op_code),
    .COND_TRUE(cond_true), .ARITH_MODE(arith_mode), .SRC_SEL(src_sel), .DST_SEL(dst_sel),
    .SHIFT_AMOUNT_REGISTER(shift_amt), .SHIFT_IMM(shift_imm), .OPERAND(operand),
    .OPERAND_CLASS(operand_class), .OPERAND_LONG(operand_long), .PRODUCT_SHIFT(product_shift),
    .OP_READY(op_ready), .DONE(done), .REJECT(reject), .ACC_A0_OUT(acc_a0),
    .ACC_A1_OUT(acc_a1), .ACC_B0_OUT(acc_b0), .ACC_B1_OUT(acc_b1), .PRODUCT(product),
    .FLAGS(flags)
  );

  // 50 ns period core clock
  always #25 ref_clk = ~ref_clk;

  // ***************************************************************
  // compare and closing tasks
  // ***************************************************************
  task automatic chk_acc(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: accumulator %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_prod(input logic [PROD_W-1:0] got, input logic [PROD_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: product %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ***************************************************************
  // operation driver
  // ***************************************************************
  // offers one operation and returns mid-cycle once its result has landed;
  // the long form puts a decoy on the first word so a wrong word is caught
  task automatic op(input assd_op_e code, input logic [1:0] dst, input logic [15:0] opd = 16'h0,
                    input logic [1:0] cls = 2'h0, input logic signed [15:0] amt = 16'sh0,
                    input logic signed [5:0] imm = 6'sh0, input logic cond = 1'b1,
                    input logic arith = 1'b1, input logic [1:0] psh = 2'h0, input logic lng = 1'b0,
                    input logic [1:0] src = 2'h0);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= code;
    dst_sel <= dst;
    src_sel <= src;
    operand <= lng ? ~opd : opd;
    operand_class <= cls;
    shift_amt <= amt;
    shift_imm <= imm;
    cond_true <= cond;
    arith_mode <= arith;
    product_shift <= psh;
    operand_long <= lng;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    if (lng) begin
      operand <= opd;
      @(negedge ref_clk);
      chk_bit(op_ready, 1'b0);
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
  endtask

  // ***************************************************************
  // test sequence
  // ***************************************************************
  // tables for the overflow boundary and the step shifts, source is -5
  int amts[2] = '{32, 33};
  logic ovf[2] = '{1'b0, 1'b1};
  logic [ACC_W-1:0] lres[2] = '{36'hb00000000, 36'h600000000};
  assd_op_e stp[4] = '{OP_SHL1, OP_SHR1, OP_LEFT_FOUR_BITS, OP_RIGHT_FOUR_BITS};
  logic [ACC_W-1:0] stx[4] = '{36'hffffffff6, 36'hffffffffd, 36'hfffffffb0, 36'hfffffffff};

  initial begin
    // quiet stimulus while reset is held
    reset <= 1'b1;
    op_valid <= 1'b0;
    op_code <= OP_NONE;
    cond_true <= 1'b0;
    arith_mode <= 1'b0;
    operand_long <= 1'b0;
    src_sel <= ACC_A0;
    dst_sel <= ACC_A0;
    operand_class <= CLS_OTHER;
    product_shift <= PSH_NONE;
    shift_amt <= '0;
    shift_imm <= '0;
    operand <= '0;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    chk_bit(op_ready, 1'b1);
    // load a0 with -5 by subtracting from zero
    op(OP_SUB, ACC_A0, 16'h0005);
    chk_acc(acc_a0, 36'hffffffffb);
    chk_bit(flags[FC], 1'b1);
    chk_bit(flags[FM], 1'b1);
    op(OP_SUB, ACC_A0, 16'h0001, CLS_B_ACC);
    chk_bit(reject, 1'b1);
    chk_acc(acc_a0, 36'hffffffffb);
    // zero-amount immediate move, logical
    op(OP_SHIFT_IMM, ACC_B0, .arith(1'b0));
    chk_acc(acc_b0, 36'hffffffffb);
    chk_bit(flags[FC], 1'b0);
    op(OP_SHIFT_REG, ACC_A1, .amt(16'sd4));
    chk_acc(acc_a1, 36'hfffffffb0);
    chk_bit(flags[FV], 1'b0);
    chk_bit(flags[FC], 1'b1);
    chk_acc(acc_a0, 36'hffffffffb);
    op(OP_SHIFT_REG, ACC_A1, .amt(-16'sd1));
    chk_acc(acc_a1, 36'hffffffffd);
    chk_bit(flags[FV], 1'b0);
    op(OP_SHIFT_REG, ACC_A1, .amt(16'sd4), .cond(1'b0));
    chk_bit(done, 1'b1);
    chk_acc(acc_a1, 36'hffffffffd);
    op(OP_SHIFT_REG, ACC_B1, .amt(16'sd36));
    chk_acc(acc_b1, 36'h0);
    chk_bit(flags[FV], 1'b1);
    chk_bit(flags[FZ], 1'b1);
    chk_bit(flags[FL], 1'b1);
    // logical immediate shifts must leave overflow standing; limit is checked after the logical register move
    op(OP_SHIFT_IMM, ACC_A1, .imm(-6'sd1), .arith(1'b0));
    chk_acc(acc_a1, 36'h7fffffffd);
    chk_bit(flags[FV], 1'b1);
    // a source other than a0 must be the one read
    op(OP_SHIFT_IMM, ACC_A1, .arith(1'b0), .src(ACC_B1));
    chk_acc(acc_a1, 36'h0);
    chk_acc(acc_b1, 36'h0);
    chk_bit(flags[FZ], 1'b1);
    chk_bit(flags[FV], 1'b1);
    op(OP_SHIFT_REG, ACC_A1, .arith(1'b0));
    chk_acc(acc_a1, 36'hffffffffb);
    chk_bit(flags[FL], 1'b1);
    chk_bit(flags[FC], 1'b0);
    op(OP_SHIFT_REG, ACC_A1, .amt(16'sd0));
    chk_bit(flags[FV], 1'b0);
    chk_bit(flags[FC], 1'b0);
    for (int i = 0; i < 2; i++) begin
      op(OP_SHIFT_REG, ACC_A1, .amt(16'(amts[i])));
      chk_acc(acc_a1, lres[i]);
      chk_bit(flags[FV], ovf[i]);
    end
    op(OP_SHIFT_IMM, ACC_A1, .imm(6'sd31));
    chk_acc(acc_a1, 36'hd80000000);
    chk_bit(flags[FV], 1'b0);
    op(OP_SHIFT_IMM, ACC_A1, .imm(-6'sd32));
    chk_acc(acc_a1, 36'hfffffffff);
    chk_bit(flags[FV], 1'b0);
    for (int i = 0; i < 4; i++) begin
      op(stp[i], ACC_A1);
      chk_acc(acc_a1, stx[i]);
    end
    op(OP_LEFT_FOUR_BITS, ACC_B1, .cond(1'b0));
    chk_acc(acc_b1, 36'h0);
    // squaring, rejects, then accumulate of the previous product
    op(OP_SQR, ACC_A0, 16'hfffd);
    chk_prod(product, 32'h00000009);
    chk_bit(done, 1'b1);
    op(OP_SQR, ACC_A0, 16'h0002, CLS_PROD);
    chk_bit(reject, 1'b1);
    chk_prod(product, 32'h00000009);
    op(OP_SQRA, ACC_A0, 16'h0002);
    chk_acc(acc_a0, 36'h000000004);
    chk_prod(product, 32'h00000004);
    // the three shifting product settings, each with a non-zero product
    op(OP_SQRA, ACC_A0, 16'h0003, .psh(PSH_LEFT1));
    chk_acc(acc_a0, 36'h00000000c);
    chk_prod(product, 32'h00000009);
    chk_bit(flags[FR], 1'b0);
    op(OP_SQRA, ACC_A0, 16'hfffe, .psh(PSH_RIGHT1));
    chk_acc(acc_a0, 36'h000000010);
    chk_prod(product, 32'h00000004);
    op(OP_SQRA, ACC_A0, 16'h0000, .psh(PSH_LEFT2));
    chk_acc(acc_a0, 36'h000000020);
    chk_prod(product, 32'h00000000);
    op(OP_SUBL, ACC_A0, 16'hffff, CLS_A_ACC);
    chk_bit(reject, 1'b1);
    op(OP_SUBH, ACC_A0, 16'h0001, CLS_B_ACC);
    chk_bit(reject, 1'b1);
    chk_acc(acc_a0, 36'h000000020);
    op(OP_SUBL, ACC_A0, 16'hffff);
    chk_acc(acc_a0, 36'hfffff0021);
    chk_bit(flags[FC], 1'b1);
    op(OP_SUBH, ACC_A0, 16'h0001);
    chk_acc(acc_a0, 36'hffffe0021);
    op(OP_SUB, ACC_A0, 16'h8000, .lng(1'b1));
    chk_acc(acc_a0, 36'hffffe8021);
    chk_bit(done, 1'b1);
    chk_bit(op_ready, 1'b1);
    finish_test();
  end

  // the sequence needs well under 400 cycles; cut a hang short
  initial begin
    #100000;
    failures++;
    finish_test();
  end

endmodule
